// >>> rtl/logic_cell_cfg.svh
/*
 * Offsets, field positions, reset values and widths for the logic cell pair.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LOGIC_CELL_CFG_SVH
`define LOGIC_CELL_CFG_SVH

// register byte offsets on the APB slave
`define OFS_TABLE_A 8'h00
`define OFS_TABLE_B 8'h04
`define OFS_CONFIG 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_STATUS 8'h10

// configuration register fields
`define CFG_GATE_LSB 0
`define CFG_GATE_MSB 7
`define CFG_CASC_LSB 8
`define CFG_CASC_MSB 11
`define CFG_SRC_LSB 12
`define CFG_SRC_MSB 13
`define CFG_ASET_BIT 14
`define CFG_MODE_LSB 16
`define CFG_MODE_MSB 17

// control and status fields
`define CTL_LOCK_BIT 0
`define STS_LOCK_BIT 0
`define STS_FFQ_BIT 1
`define STS_TOUT_BIT 2
`define STS_COUT_BIT 3

// reset values
`define RST_TABLE 16'h0000
`define RST_GATE 8'h00
`define RST_CASC 4'h0
`define RST_ASET 1'b0

`endif

// >>> rtl/logic_cell_pkg.sv
/*
 * Types shared by the logic cell pair and its testbench.
 * Assumes the constants header is on the include path.
 */
`include "logic_cell_cfg.svh"

package logic_cell_pkg;

    // how the two tables are combined into the result
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_MUX5 = 2'b01,
        MODE_WIDE = 2'b10,
        MODE_SPARE = 2'b11
    } comb_mode_type;

    // flip-flop data source
    typedef enum logic [1:0] {
        SRC_TABLE = 2'b00,
        SRC_CASCADE = 2'b01,
        SRC_DIRECT = 2'b10,
        SRC_SPARE = 2'b11
    } ff_src_type;

endpackage : logic_cell_pkg

// >>> rtl/four_input_table.sv
/*
 * Lookup of one bit from a configured truth table, indexed by the inputs.
 * Assumes the table contents are held stable by the instantiating module.
 */
`timescale 1ns/10ps

module four_input_table #(
    parameter int IN_W = 4
) (
    input wire logic [(1 << IN_W) - 1:0] table_bits,
    input wire logic [IN_W - 1:0] index,
    output wire logic result
);

    assign result = table_bits[index];

endmodule : four_input_table

// >>> rtl/logic_cell_pair.sv
/*
 * Two tandem logic cells with cascade logic and one cell flip-flop,
 * configured over APB during initialization and locked afterwards.
 * Assumes all inputs are synchronous to clk; the cell clock is sampled.
 */
`timescale 1ns/10ps
`include "logic_cell_cfg.svh"

module logic_cell_pair
    import logic_cell_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [8:0] lookup_inputs,
    input wire logic cascade_in,
    input wire logic direct_ff_input,
    input wire logic cell_clock_in,
    input wire logic cell_clock_enable,
    input wire logic async_ctrl,
    output logic table_out,
    output logic cascade_out,
    output logic ff_q
);

    logic [15:0] table_a_reg;
    logic [15:0] table_a_next;
    logic [15:0] table_b_reg;
    logic [15:0] table_b_next;
    logic [7:0] gate_reg;
    logic [7:0] gate_next;
    logic [3:0] casc_reg;
    logic [3:0] casc_next;
    ff_src_type src_reg;
    ff_src_type src_next;
    logic aset_reg;
    logic aset_next;
    comb_mode_type mode_reg;
    comb_mode_type mode_next;
    logic locked_reg;
    logic locked_next;
    logic clk_prev_reg;
    logic ff_q_next;

    // bus decode
    wire access = psel && penable && !pready;
    wire wr = access && pwrite;
    wire hit_a = (paddr == `OFS_TABLE_A);
    wire hit_b = (paddr == `OFS_TABLE_B);
    wire hit_cfg = (paddr == `OFS_CONFIG);
    wire hit_ctl = (paddr == `OFS_CONTROL);
    wire hit_sts = (paddr == `OFS_STATUS);
    wire hit_cfg_any = hit_a || hit_b || hit_cfg;
    wire mapped = hit_cfg_any || hit_ctl || hit_sts;
    // configuration writes after lock are refused, not silently stored
    wire cfg_wr_ok = wr && hit_cfg_any && !locked_reg;
    wire err = access && (!mapped || (pwrite && (hit_cfg_any && locked_reg || hit_sts)));

    // lookup datapath
    wire fa;
    wire fb;
    wire fgate;
    wire casc_out_w;
    wire [3:0] idx_b = (mode_reg == MODE_WIDE) ? lookup_inputs[7:4] : lookup_inputs[3:0];

    four_input_table #(.IN_W(4)) u_table_a (
        .table_bits(table_a_reg),
        .index(lookup_inputs[3:0]),
        .result(fa)
    );

    four_input_table #(.IN_W(4)) u_table_b (
        .table_bits(table_b_reg),
        .index(idx_b),
        .result(fb)
    );

    // wide mode: a three-input gate of both results and a ninth input
    four_input_table #(.IN_W(3)) u_gate (
        .table_bits(gate_reg),
        .index({lookup_inputs[8], fb, fa}),
        .result(fgate)
    );

    wire mux5 = lookup_inputs[4] ? fb : fa;
    wire result = (mode_reg == MODE_MUX5) ? mux5 :
                  (mode_reg == MODE_WIDE) ? fgate : fa;

    four_input_table #(.IN_W(2)) u_cascade (
        .table_bits(casc_reg),
        .index({cascade_in, result}),
        .result(casc_out_w)
    );

    // flip-flop data select and cell clock edge
    wire ff_d = (src_reg == SRC_CASCADE) ? cascade_in :
                (src_reg == SRC_DIRECT) ? direct_ff_input : result;
    wire cell_edge = cell_clock_in && !clk_prev_reg;
    wire capture = cell_edge && cell_clock_enable;

    // async control wins over any capture; it is sampled, so it acts next clk
    always_comb begin
        if (async_ctrl) begin
            ff_q_next = aset_reg;
        end else if (capture) begin
            ff_q_next = ff_d;
        end else begin
            ff_q_next = ff_q;
        end
    end

    always_comb begin
        table_a_next = table_a_reg;
        table_b_next = table_b_reg;
        gate_next = gate_reg;
        casc_next = casc_reg;
        src_next = src_reg;
        aset_next = aset_reg;
        mode_next = mode_reg;
        locked_next = locked_reg;
        if (cfg_wr_ok && hit_a) begin
            table_a_next = pwdata[15:0];
        end
        if (cfg_wr_ok && hit_b) begin
            table_b_next = pwdata[15:0];
        end
        if (cfg_wr_ok && hit_cfg) begin
            gate_next = pwdata[`CFG_GATE_MSB:`CFG_GATE_LSB];
            casc_next = pwdata[`CFG_CASC_MSB:`CFG_CASC_LSB];
            src_next = ff_src_type'(pwdata[`CFG_SRC_MSB:`CFG_SRC_LSB]);
            aset_next = pwdata[`CFG_ASET_BIT];
            mode_next = comb_mode_type'(pwdata[`CFG_MODE_MSB:`CFG_MODE_LSB]);
        end
        // lock ends initialization and only reset clears it
        if (wr && hit_ctl && pwdata[`CTL_LOCK_BIT]) begin
            locked_next = 1'b1;
        end
    end

    wire [31:0] cfg_word = {14'h0000, mode_reg, 1'b0, aset_reg, src_reg, casc_reg, gate_reg};
    wire [31:0] sts_word = {28'h000_0000, cascade_out, table_out, ff_q, locked_reg};
    wire [31:0] rd_word = hit_a ? {16'h0000, table_a_reg} :
                          hit_b ? {16'h0000, table_b_reg} :
                          hit_cfg ? cfg_word :
                          hit_ctl ? {31'h0000_0000, locked_reg} :
                          hit_sts ? sts_word : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            table_a_reg <= `RST_TABLE;
            table_b_reg <= `RST_TABLE;
            gate_reg <= `RST_GATE;
            casc_reg <= `RST_CASC;
            src_reg <= SRC_TABLE;
            aset_reg <= `RST_ASET;
            mode_reg <= MODE_SINGLE;
            locked_reg <= 1'b0;
        end else begin
            table_a_reg <= table_a_next;
            table_b_reg <= table_b_next;
            gate_reg <= gate_next;
            casc_reg <= casc_next;
            src_reg <= src_next;
            aset_reg <= aset_next;
            mode_reg <= mode_next;
            locked_reg <= locked_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clk_prev_reg <= 1'b0;
            ff_q <= 1'b0;
            table_out <= 1'b0;
            cascade_out <= 1'b0;
        end else begin
            clk_prev_reg <= cell_clock_in;
            ff_q <= ff_q_next;
            table_out <= result;
            cascade_out <= casc_out_w;
        end
    end

    // one wait state: pready rises one cycle into the access phase
    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= err;
            prdata <= (access && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    AST_SINGLE_FUNC: assert property (@(posedge clk) disable iff (srst)
        (mode_reg == MODE_SINGLE) |=> (table_out == $past(fa)))
        else $error("single mode output differs from table a");

    AST_ROM16: assert property (@(posedge clk) disable iff (srst)
        (mode_reg == MODE_SINGLE) && $stable(table_a_reg)
        |=> (table_out == $past(table_a_reg[lookup_inputs[3:0]])))
        else $error("rom16 read returned wrong location");

    AST_ROM32: assert property (@(posedge clk) disable iff (srst)
        (mode_reg == MODE_MUX5)
        |=> (table_out == $past(lookup_inputs[4] ? table_b_reg[lookup_inputs[3:0]]
                                                 : table_a_reg[lookup_inputs[3:0]])))
        else $error("five input result wrong");

    AST_WIDE: assert property (@(posedge clk) disable iff (srst)
        (mode_reg == MODE_WIDE)
        |=> (table_out == $past(gate_reg[{lookup_inputs[8], table_b_reg[lookup_inputs[7:4]],
                                          table_a_reg[lookup_inputs[3:0]]}])))
        else $error("wide function result wrong");

    AST_LOCKED_FIXED: assert property (@(posedge clk) disable iff (srst)
        locked_reg |=> ($stable(table_a_reg) && $stable(table_b_reg) && $stable(gate_reg)))
        else $error("table changed after lock");

    AST_LOCK_ERR: assert property (@(posedge clk) disable iff (srst)
        (access && pwrite && hit_a && locked_reg) |=> (pready && pslverr))
        else $error("locked table write not refused");

    AST_CASCADE: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> (cascade_out == $past(casc_reg[{cascade_in, result}])))
        else $error("cascade out wrong");

    AST_CAPTURE: assert property (@(posedge clk) disable iff (srst)
        (!async_ctrl && !clk_prev_reg && cell_clock_in && cell_clock_enable)
        |=> (ff_q == $past(ff_d)))
        else $error("enabled edge did not capture");

    AST_HOLD: assert property (@(posedge clk) disable iff (srst)
        (!async_ctrl && !(cell_clock_in && !clk_prev_reg && cell_clock_enable)) |=> $stable(ff_q))
        else $error("flip-flop changed without enabled edge");

    AST_ASYNC_FORCE: assert property (@(posedge clk) disable iff (srst)
        async_ctrl |=> (ff_q == $past(aset_reg)))
        else $error("async control did not force value");

    AST_DIRECT_SRC: assert property (@(posedge clk) disable iff (srst)
        (!async_ctrl && capture && src_reg == SRC_DIRECT) |=> (ff_q == $past(direct_ff_input)))
        else $error("direct input not captured");

    AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (srst)
        locked_reg |=> (locked_reg && $stable(src_reg) && $stable(aset_reg) && $stable(mode_reg)))
        else $error("configuration changed after lock");

    AST_OVERRIDE: assert property (@(posedge clk) disable iff (srst)
        async_ctrl [*2] ##0 $stable(aset_reg) |=> (ff_q == $past(aset_reg)) && $stable(ff_q))
        else $error("clock activity disturbed forced value");

endmodule : logic_cell_pair

// >>> test/neighbour_cell_model.sv
/* Model of the neighbouring cell: cell clock and cascade signal.
   Assumes requests come from the bench just after a rising clk edge. */
`timescale 1ns/10ps

module neighbour_cell_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic carry,
    output logic cell_clock_in,
    output logic cascade_in
);
    // registered, so both change only after a clk edge as fabric outputs do;
    // the unknown before the first edge falls inside the block's reset
    always @(posedge clk) begin
        cell_clock_in <= fire;
        cascade_in <= carry;
    end
endmodule : neighbour_cell_model

// >>> test/logic_cell_pair_tb.sv
/* Self-checking bench for logic_cell_pair over APB and the cell pins.
   Assumes the neighbour model and the constants header are compiled with it. */
`timescale 1ns/10ps
`include "logic_cell_cfg.svh"

module logic_cell_pair_tb
    import logic_cell_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic fire = 1'b0, carry = 1'b0, direct_ff_input = 1'b0;
    logic cell_clock_enable = 1'b0, async_ctrl = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [8:0] lookup_inputs = 9'h000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, cell_clock_in, cascade_in, table_out, cascade_out, ff_q;
    int errors = 0;
    int checked = 0;
    localparam logic [15:0] ta = 16'h6996;
    localparam logic [15:0] tb = 16'hf00f;
    localparam logic [7:0] gate = 8'h1e;

    logic_cell_pair dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lookup_inputs(lookup_inputs),
        .cascade_in(cascade_in), .direct_ff_input(direct_ff_input),
        .cell_clock_in(cell_clock_in), .cell_clock_enable(cell_clock_enable),
        .async_ctrl(async_ctrl), .table_out(table_out), .cascade_out(cascade_out),
        .ff_q(ff_q));
    neighbour_cell_model nb (.clk(clk), .fire(fire), .carry(carry),
        .cell_clock_in(cell_clock_in), .cascade_in(cascade_in));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic finish_test;
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask : chk

    task automatic chkq(input logic exp);
        chk({31'h0000_0000, ff_q}, {31'h0000_0000, exp});
    endtask : chkq

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 8) begin
            errors++;
            finish_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic look(input logic [8:0] v, input logic exp);
        @(posedge clk);
        lookup_inputs <= v;
        @(posedge clk);
        #1;
        chk({31'h0000_0000, table_out}, {31'h0000_0000, exp});
    endtask : look

    // only the chosen path carries v, the other two carry its inverse
    task automatic set_d(input int s, input logic v);
        @(posedge clk);
        lookup_inputs <= {8'h00, (s == 0) ? v : ~v};
        carry <= (s == 1) ? v : ~v;
        direct_ff_input <= (s == 2) ? v : ~v;
    endtask : set_d

    task automatic pulse(input logic en);
        @(posedge clk);
        cell_clock_enable <= en;
        fire <= 1'b1;
        repeat (2) @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : pulse

    task automatic t_regs;
        apb(1'b0, `OFS_CONFIG, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0000);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
    endtask : t_regs

    task automatic t_tables;
        apb(1'b1, `OFS_TABLE_A, {16'h0000, ta});
        apb(1'b1, `OFS_TABLE_B, {16'h0000, tb});
        for (int i = 0; i < 16; i++) look(i[8:0], ta[i[3:0]]);
        apb(1'b1, `OFS_CONFIG, {14'h0000, MODE_MUX5, 16'h0000});
        for (int i = 0; i < 32; i++) look(i[8:0], i[4] ? tb[i[3:0]] : ta[i[3:0]]);
        apb(1'b1, `OFS_CONFIG, {14'h0000, MODE_WIDE, 8'h00, gate});
        for (int i = 0; i < 512; i++) look(i[8:0], gate[{i[8], tb[i[7:4]], ta[i[3:0]]}]);
    endtask : t_tables

    task automatic t_casc;
        apb(1'b1, `OFS_CONFIG, 32'h0000_0600);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            carry <= i[4];
            lookup_inputs <= {5'h00, i[3:0]};
            repeat (2) @(posedge clk);
            #1;
            chk({31'h0000_0000, cascade_out}, {31'h0000_0000, i[4] ^ ta[i[3:0]]});
        end
    endtask : t_casc

    task automatic t_ff;
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `OFS_CONFIG, 32'(s) << 12);
            set_d(s, 1'b1);
            pulse(1'b0);
            chkq(1'b0);
            pulse(1'b1);
            chkq(1'b1);
            set_d(s, 1'b0);
            pulse(1'b1);
            chkq(1'b0);
        end
    endtask : t_ff

    task automatic t_async;
        apb(1'b1, `OFS_CONFIG, 32'h0000_6000);
        set_d(2, 1'b0);
        @(posedge clk);
        async_ctrl <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chkq(1'b1);
        pulse(1'b1);
        chkq(1'b1);
        @(posedge clk);
        async_ctrl <= 1'b0;
        pulse(1'b1);
        chkq(1'b0);
        apb(1'b1, `OFS_CONFIG, 32'h0000_2000);
        set_d(2, 1'b1);
        pulse(1'b1);
        chkq(1'b1);
        @(posedge clk);
        async_ctrl <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chkq(1'b0);
        @(posedge clk);
        async_ctrl <= 1'b0;
    endtask : t_async

    task automatic t_lock;
        apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
        apb(1'b0, `OFS_CONTROL, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0002);
        apb(1'b1, `OFS_TABLE_A, 32'h0000_ffff);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, `OFS_CONFIG, 32'h0003_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, `OFS_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b0, `OFS_TABLE_A, 32'h0000_0000);
        chk(rd, {16'h0000, ta});
        look(9'h001, ta[1]);
        apb(1'b0, `OFS_CONFIG, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_4000);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_000a);
    endtask : t_lock

    // a second reset must clear the lock and table A
    task automatic t_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `OFS_CONTROL, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0000);
        apb(1'b0, `OFS_TABLE_A, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask : t_reset

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_tables();
        t_casc();
        t_ff();
        t_async();
        t_lock();
        t_reset();
        finish_test();
    end
endmodule : logic_cell_pair_tb
